// ==== rtl/swd_supervisor.sv ====
// Supervisor register block: keyed watchdog, reset-cause log, brownout
// threshold, write-protect and prescale register, over an APB slave.
// Assumes the system reset tree applies presetn on every supervisor reset
// and that por_n marks power-on; tick inputs come from other clock domains.
// Notes on behaviour
// - Brownout threshold register holds a code for 2.3 V to 4.4 V trip.
// - Protect bits 7,6,5 lock ident, calibration and application groups.
// - Protect bit 4 makes brownout threshold writes ignored.
// - Protect bit 3 enables the slow-clock output.
// - Protect bits 2:0 select oscillator divisor 1 to 128.
// - Reset-cause keeps four history flags, surviving later resets.
// - Cause flags clear only by writing one; hardware never clears.
// - Supply below threshold sets cause bit 3.
// - Power-on reset sets cause bit 0.
// - Power-on also sets brownout flag; bits 0 and 3 read set after power-on.
// - Wrong kick code reset sets cause bit 2.
// - Watchdog expiry reset sets cause bit 1.
// - Each accepted kick reloads the counter.
// - Timeout register holds seven bits; bit 7 reserved.
// - Counter decrements on 32 kHz or clock-output tick per config bit 2.
// - On clock-output, countdown pauses while fast clock stopped.
// - Watchdog disabled after reset; first timeout write starts it.
// - Once started, clock choice and timeout writes are ignored.
// - Clock choice one selects clock-output, zero selects 32 kHz.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "swd_defines.svh"
module swd_supervisor
  import swd_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SWD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources and ticks from other domains
  input wire logic por_n,
  input wire logic brownout_level,
  input wire logic slow_tick,
  input wire logic clock_output_pin,
  input wire logic fast_clock_run,
  // Controls to neighbouring blocks
  output logic [7:0] brownout_threshold,
  output logic slow_clock_output,
  output logic [2:0] tuned_oscillator_div,
  output logic [7:0] tuned_oscillator_divisor,
  output var swd_protect_s group_protect,
  output logic wd_reset_req
);

  // Cause log lives in an always-on domain: no presetn on it.
  logic [3:0] reset_cause_reg;
  logic [7:0] brownout_threshold_reg;
  logic [7:0] protect_and_prescale_reg;
  logic [7:0] config_reg;
  logic [6:0] watchdog_timeout_reg;
  logic [6:0] wd_count_reg;
  logic [2:0] slow_sync_reg;
  logic [2:0] cko_sync_reg;
  logic [1:0] run_sync_reg;
  logic [1:0] brown_sync_reg;
  logic [1:0] por_sync_reg;
  logic por_seen_reg;
  swd_state_e state_reg;
  swd_expect_e expect_reg;
  logic [31:0] prdata_reg;

  function automatic logic [7:0] swd_div(input logic [2:0] n);
    swd_div = 8'h01 << n;
  endfunction

  function automatic logic hit(input logic [`SWD_ADDR_W-1:0] a,
                               input logic [`SWD_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic wr;
  logic mapped;
  logic lane0;
  logic [7:0] wbyte;
  logic tick_slow;
  logic tick_cko;
  logic tick;
  logic kick_wr;
  logic kick_ok;
  logic kick_bad;
  logic expired;
  logic zero_trip;
  logic start_wr;
  logic count_dec;
  logic kick_take;
  logic brown_lock;
  logic sel_brown;
  logic sel_prot;
  logic sel_cause;
  logic sel_kick;
  logic sel_tmo;
  logic sel_cfg;
  logic [7:0] rd_byte;

  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];
  assign mapped = hit(paddr, `SWD_OFF_BROWNOUT) | hit(paddr, `SWD_OFF_PROTECT)
    | hit(paddr, `SWD_OFF_CAUSE) | hit(paddr, `SWD_OFF_KICK)
    | hit(paddr, `SWD_OFF_TIMEOUT) | hit(paddr, `SWD_OFF_CONFIG);
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_reg;

  // One decode per register, shared by the write and read paths
  assign sel_brown = hit(paddr, `SWD_OFF_BROWNOUT);
  assign sel_prot = hit(paddr, `SWD_OFF_PROTECT);
  assign sel_cause = hit(paddr, `SWD_OFF_CAUSE);
  assign sel_kick = hit(paddr, `SWD_OFF_KICK);
  assign sel_tmo = hit(paddr, `SWD_OFF_TIMEOUT);
  assign sel_cfg = hit(paddr, `SWD_OFF_CONFIG);

  // Synchronisers; only the second stage onward is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_sync_reg <= 3'h0;
    end else begin
      slow_sync_reg <= {slow_sync_reg[1:0], slow_tick};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cko_sync_reg <= 3'h0;
    end else begin
      cko_sync_reg <= {cko_sync_reg[1:0], clock_output_pin};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_sync_reg <= 2'h0;
    end else begin
      run_sync_reg <= {run_sync_reg[0], fast_clock_run};
    end
  end

  // Brownout level is a slow analog flag; two flops are plenty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brown_sync_reg <= 2'h0;
    end else begin
      brown_sync_reg <= {brown_sync_reg[0], brownout_level};
    end
  end

  // POR pin caught by two flops, no async reset so the edge is seen
  always_ff @(posedge pclk) begin
    por_sync_reg <= {por_sync_reg[0], por_n};
  end

  assign tick_slow = slow_sync_reg[1] & ~slow_sync_reg[2];
  // Pin edges are ignored while the fast clock is reported stopped
  assign tick_cko = cko_sync_reg[1] & ~cko_sync_reg[2]
    & run_sync_reg[1];
  assign tick = config_reg[`SWD_BIT_CLKSEL]
    ? tick_cko : tick_slow;

  // Either code is fine until one has been taken
  function automatic logic code_ok(input logic [7:0] b,
                                   input swd_expect_e ex);
    code_ok = (b == `SWD_CODE_A && ex != SWD_EXP_B)
      || (b == `SWD_CODE_B && ex != SWD_EXP_A);
  endfunction

  function automatic swd_expect_e after_code(input logic [7:0] b);
    after_code = (b == `SWD_CODE_A) ? SWD_EXP_B : SWD_EXP_A;
  endfunction

  assign kick_wr = wr & lane0 & sel_kick & (state_reg == SWD_RUN);
  assign kick_ok = code_ok(wbyte, expect_reg);
  assign kick_take = kick_wr & kick_ok;
  assign kick_bad = kick_wr & ~kick_ok;
  assign expired = (state_reg == SWD_RUN) & tick & (wd_count_reg == 7'h01)
    & ~kick_wr;
  // A zero timeout trips at once instead of waiting a full wrap
  assign zero_trip = (state_reg == SWD_RUN) & (wd_count_reg == 7'h00)
    & ~kick_wr;
  assign start_wr = wr & lane0 & sel_tmo & (state_reg == SWD_IDLE);
  assign count_dec = (state_reg == SWD_RUN) & tick & ~kick_wr & ~expired
    & (wd_count_reg != 7'h00);

  // Watchdog state; a trip is left only through presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SWD_IDLE;
    end else begin
      unique case (state_reg)
        SWD_IDLE: begin
          if (start_wr) begin
            state_reg <= SWD_RUN;
          end
        end
        SWD_RUN: begin
          if (kick_bad || expired || zero_trip) begin
            state_reg <= SWD_TRIP;
          end
        end
        SWD_TRIP: begin
          state_reg <= SWD_TRIP;
        end
        default: begin
          state_reg <= SWD_IDLE;
        end
      endcase
    end
  end

  // Watchdog counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_count_reg <= 7'h00;
    end else if (start_wr) begin
      wd_count_reg <= wbyte[`SWD_TMO_MSB:0];
    end else if (kick_take) begin
      wd_count_reg <= watchdog_timeout_reg;
    end else if (count_dec) begin
      wd_count_reg <= wd_count_reg - 7'h01;
    end
  end

  // Code alternation: the value owed by the next kick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expect_reg <= SWD_EXP_ANY;
    end else if (kick_take) begin
      expect_reg <= after_code(wbyte);
    end
  end

  // Held until the system reset tree answers with presetn
  assign wd_reset_req = (state_reg == SWD_TRIP);

  // Timeout value, frozen once running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_timeout_reg <= 7'h00;
    end else if (start_wr) begin
      watchdog_timeout_reg <= wbyte[`SWD_TMO_MSB:0];
    end
  end

  // Clock choice, frozen once running as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= `SWD_CFG_RST;
    end else if (wr && lane0 && sel_cfg
                 && state_reg == SWD_IDLE) begin
      config_reg <= wbyte & `SWD_CFG_MASK;
    end
  end

  assign brown_lock = protect_and_prescale_reg[`SWD_BIT_WP_BROWN];

  // Threshold register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_threshold_reg <= `SWD_BROWN_RST;
    end else if (wr && lane0 && sel_brown && !brown_lock) begin
      brownout_threshold_reg <= wbyte & `SWD_BROWN_MASK;
    end
  end

  // Protect register is never locked by its own bits, or it could not
  // be opened again without a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_and_prescale_reg <= `SWD_PROT_RST;
    end else if (wr && lane0 && sel_prot) begin
      protect_and_prescale_reg <= wbyte;
    end
  end

  assign brownout_threshold = brownout_threshold_reg;
  assign slow_clock_output =
    protect_and_prescale_reg[`SWD_BIT_SLOW_EN];
  assign tuned_oscillator_div =
    protect_and_prescale_reg[`SWD_DIV_MSB:0];
  assign tuned_oscillator_divisor =
    swd_div(protect_and_prescale_reg[`SWD_DIV_MSB:0]);
  // Other groups' write enables gate on these
  assign group_protect.wp_ident =
    protect_and_prescale_reg[`SWD_BIT_WP_IDENT];
  assign group_protect.wp_cal =
    protect_and_prescale_reg[`SWD_BIT_WP_CAL];
  assign group_protect.wp_app =
    protect_and_prescale_reg[`SWD_BIT_WP_APP];

  // Cause log: set wins over write-one clear
  logic cause_wr;
  logic [3:0] cause_set;
  logic [3:0] cause_clr;
  logic por_edge;
  assign cause_wr = wr & lane0 & sel_cause;
  assign cause_clr = cause_wr ? wbyte[`SWD_CAUSE_MSB:0] : 4'h0;
  assign por_edge = por_sync_reg[1] & ~por_seen_reg;
  always_comb begin
    cause_set = 4'h0;
    cause_set[`SWD_CAUSE_POR] = por_edge;
    // Power-on always logs a brownout as well
    cause_set[`SWD_CAUSE_BROWN] = por_edge
      | brown_sync_reg[1];
    cause_set[`SWD_CAUSE_CODE] = kick_bad;
    cause_set[`SWD_CAUSE_EXPIRE] = expired | zero_trip;
  end

  // Power-on edge detector, outside presetn like the log itself
  always_ff @(posedge pclk) begin
    por_seen_reg <= por_sync_reg[1];
  end

  // Flags 0 and 3 set when por_n rises, flags 1 and 2 stay unknown until a write of one or a watchdog trip; only software clears them
  always_ff @(posedge pclk) begin
    reset_cause_reg <= (reset_cause_reg & ~cause_clr) | cause_set;
  end

  // Read mux; the kick register is write-only and reads zero
  always_comb begin
    rd_byte = 8'h00;
    if (sel_brown) begin
      rd_byte = brownout_threshold_reg;
    end
    if (sel_prot) begin
      rd_byte = protect_and_prescale_reg;
    end
    if (sel_cause) begin
      rd_byte = {4'h0, reset_cause_reg};
    end
    if (sel_kick) begin
      rd_byte = 8'h00;
    end
    if (sel_tmo) begin
      rd_byte = {1'b0, watchdog_timeout_reg};
    end
    if (sel_cfg) begin
      rd_byte = config_reg;
    end
  end

  // Read data loads at the setup edge so it stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

endmodule
`default_nettype wire

// ==== rtl/swd_defines.svh ====
// Constants for the supervisor watchdog and reset-cause register block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SWD_DEFINES_SVH
`define SWD_DEFINES_SVH
`define SWD_OFF_BROWNOUT 12'h040
`define SWD_OFF_PROTECT 12'h05C
`define SWD_OFF_CAUSE 12'h06C
`define SWD_OFF_KICK 12'h070
`define SWD_OFF_TIMEOUT 12'h074
`define SWD_OFF_CONFIG 12'h038
`define SWD_IDX_BROWNOUT 8'h10
`define SWD_IDX_PROTECT 8'h17
`define SWD_IDX_CAUSE 8'h1B
`define SWD_IDX_KICK 8'h1C
`define SWD_IDX_TIMEOUT 8'h1D
`define SWD_IDX_CONFIG 8'h0E
`define SWD_BIT_WP_IDENT 7
`define SWD_BIT_WP_CAL 6
`define SWD_BIT_WP_APP 5
`define SWD_BIT_WP_BROWN 4
`define SWD_BIT_SLOW_EN 3
`define SWD_BIT_CLKSEL 2
`define SWD_CAUSE_POR 0
`define SWD_CAUSE_EXPIRE 1
`define SWD_CAUSE_CODE 2
`define SWD_CAUSE_BROWN 3
`define SWD_CODE_A 8'h5A
`define SWD_CODE_B 8'hC3
`define SWD_CAUSE_POR_VAL 8'h09
`define SWD_BROWN_RST 8'h00
`define SWD_PROT_RST 8'h00
`define SWD_CFG_RST 8'h00
`define SWD_TMO_MASK 8'h7F
`define SWD_BROWN_MASK 8'h7F
`define SWD_CFG_MASK 8'h04
`define SWD_ADDR_W 12
`define SWD_DIV_MSB 2
`define SWD_TMO_MSB 6
`define SWD_CAUSE_MSB 3
`endif

// ==== rtl/swd_pkg.sv ====
// Types for the supervisor watchdog block.
// Assumes swd_defines.svh is on the include path.
`include "swd_defines.svh"
package swd_pkg;
  typedef struct packed {
    logic wp_ident;
    logic wp_cal;
    logic wp_app;
  } swd_protect_s;
  typedef enum logic [1:0] {
    SWD_IDLE = 2'b00,
    SWD_RUN = 2'b01,
    SWD_TRIP = 2'b10
  } swd_state_e;
  typedef enum logic [1:0] {
    SWD_EXP_ANY = 2'b00,
    SWD_EXP_A = 2'b01,
    SWD_EXP_B = 2'b10
  } swd_expect_e;
endpackage

// ==== tb/swd_asserts.sv ====
// Checker for the supervisor block ports.
// Assumes binding onto swd_supervisor.
`timescale 1ns/1ps
`default_nettype none
`include "swd_defines.svh"
module swd_asserts
  import swd_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Outputs
  input wire logic [7:0] brownout_threshold,
  input wire logic slow_clock_output,
  input wire logic [2:0] tuned_oscillator_div,
  input wire logic [7:0] tuned_oscillator_divisor,
  input wire swd_protect_s group_protect,
  input wire logic wd_reset_req
);
  logic wr, wpb, run;
  assign wr = psel && penable && pwrite;
  // Shadow of protect bit 4 and of watchdog start
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) wpb <= 1'b0;
    else if (wr && paddr == `SWD_OFF_PROTECT) wpb <= pwdata[4];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) run <= 1'b0;
    else if (wr && paddr == `SWD_OFF_TIMEOUT) run <= 1'b1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_prot_slow: assert property (
    wr && paddr == `SWD_OFF_PROTECT
    |=> slow_clock_output == $past(pwdata[3])) else $error("slow en");
  a_prot_fields: assert property (
    wr && paddr == `SWD_OFF_PROTECT
    |=> group_protect == $past(pwdata[7:5])
    && tuned_oscillator_div == $past(pwdata[2:0])) else $error("protect");
  a_div_map: assert property (tuned_oscillator_divisor
    == 8'h01 << tuned_oscillator_div) else $error("divisor");
  a_brown_write: assert property (wr && paddr == `SWD_OFF_BROWNOUT
    && !wpb |=> brownout_threshold == ($past(pwdata[7:0]) & 8'h7F))
    else $error("brownout write");
  a_brown_lock: assert property (wr && paddr == `SWD_OFF_BROWNOUT
    && wpb |=> $stable(brownout_threshold)) else $error("brownout lock");
  a_trip_hold: assert property (wd_reset_req
    |=> wd_reset_req) else $error("trip dropped");
  a_idle_quiet: assert property (!run |-> !wd_reset_req)
    else $error("idle trip");
  a_bad_kick: assert property (
    run && wr && paddr == `SWD_OFF_KICK
    && pwdata[7:0] != 8'h5A && pwdata[7:0] != 8'hC3
    |-> ##[1:3] wd_reset_req) else $error("bad kick");
endmodule
bind swd_supervisor swd_asserts u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .brownout_threshold, .slow_clock_output,
  .tuned_oscillator_div, .tuned_oscillator_divisor, .group_protect,
  .wd_reset_req);
`default_nettype wire

// ==== tb/swd_host.sv ====
// Host model: APB master for the supervisor registers.
// Assumes each task is entered just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module swd_host (
  // APB
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  logic alt = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e,
    output logic t);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    t = n >= 64;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Either code may open; later ones alternate
  task automatic kick(output logic t);
    logic [31:0] r;
    logic e;
    xfer(1'b1, 12'h070, alt ? 32'hC3 : 32'h5A, r, e, t);
    alt = !alt;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the supervisor block.
// Assumes swd_host as APB master and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "swd_defines.svh"
module testbench;
  import swd_pkg::*;
  logic pclk = 0, presetn = 0, por_n = 0, brownout_level = 0;
  logic slow_tick = 0, clock_output_pin = 0, fast_clock_run = 1;
  logic psel, penable, pwrite, pready, pslverr, wd_reset_req, e, t;
  logic slow_clock_output;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, d;
  logic [7:0] brownout_threshold, tuned_oscillator_divisor, v, bt;
  logic [2:0] tuned_oscillator_div;
  swd_protect_s group_protect;
  int num_errors = 0, tests_run = 0;
  initial forever #50 pclk = ~pclk;
  swd_host h (.pclk, .pready, .pslverr, .prdata, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  swd_supervisor dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .por_n,
    .brownout_level, .slow_tick, .clock_output_pin, .fast_clock_run,
    .brownout_threshold, .slow_clock_output, .tuned_oscillator_div,
    .tuned_oscillator_divisor, .group_protect, .wd_reset_req);
  function automatic logic [7:0] f_div(input logic [2:0] n);
    return 8'h01 << n;
  endfunction
  task automatic stop_test;
    $display("tests %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    stop_test;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dd);
    h.xfer(1'b1, a, dd, r, e, t);
    if (t) hang;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    h.xfer(1'b0, a, 32'h0, r, e, t);
    if (t) hang;
    chk(r, x);
  endtask
  task automatic ticks(input logic s, input int k);
    repeat (k) begin
      if (s) clock_output_pin <= 1'b1;
      else slow_tick <= 1'b1;
      repeat (4) @(posedge pclk);
      clock_output_pin <= 1'b0;
      slow_tick <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic rst;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic trip;
    int n;
    n = 0;
    while (wd_reset_req !== 1'b1) begin
      @(posedge pclk);
      if (++n > 40) hang;
    end
    rst;
  endtask
  initial begin
    void'($urandom(47));
    repeat (8) @(posedge pclk);
    por_n <= 1'b1;
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    h.xfer(1'b0, `SWD_OFF_CAUSE, 32'h0, r, e, t);
    if (t) hang;
    chk(r & 32'h9, 32'h9);
    wr(`SWD_OFF_CAUSE, 32'hF);
    rd(`SWD_OFF_CAUSE, 32'h0);
    rd(`SWD_OFF_TIMEOUT, 32'h0);
    rd(`SWD_OFF_KICK, 32'h0);
    rd(12'hFFC, 32'h0);
    chk(e, 1);
    brownout_level <= 1'b1;
    repeat (5) @(posedge pclk);
    brownout_level <= 1'b0;
    repeat (4) @(posedge pclk);
    wr(`SWD_OFF_CAUSE, 32'h0);
    rst;
    rd(`SWD_OFF_CAUSE, 32'h8);
    wr(`SWD_OFF_CAUSE, 32'h8);
    $display("test cause log done");
    bt = 8'h00;
    // Bit 5 kept clear: it guards the application group, not this register
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      v[2:0] = i[2:0];
      v[5] = 1'b0;
      wr(`SWD_OFF_PROTECT, {24'h0, v});
      chk(slow_clock_output, v[3]);
      chk({group_protect, tuned_oscillator_div},
        {v[7:5], v[2:0]});
      chk(tuned_oscillator_divisor, f_div(i[2:0]));
      d = $urandom;
      wr(`SWD_OFF_BROWNOUT, d);
      if (!v[4]) bt = d[7:0] & 8'h7F;
      rd(`SWD_OFF_BROWNOUT, {24'h0, bt});
      chk(brownout_threshold, bt);
    end
    $display("test registers done");
    rst;
    wr(`SWD_OFF_KICK, 32'h11);
    ticks(0, 3);
    chk(wd_reset_req, 0);
    wr(`SWD_OFF_TIMEOUT, 32'h83);
    wr(`SWD_OFF_TIMEOUT, 32'h7F);
    wr(`SWD_OFF_CONFIG, 32'h4);
    rd(`SWD_OFF_TIMEOUT, 32'h3);
    repeat (3) begin
      h.kick(t);
      if (t) hang;
      ticks(0, 2);
      ticks(1, 3);
    end
    chk(wd_reset_req, 0);
    wr(`SWD_OFF_KICK, h.alt ? 32'h5A : 32'hC3);
    trip;
    rd(`SWD_OFF_CAUSE, 32'h4);
    rd(`SWD_OFF_TIMEOUT, 32'h0);
    wr(`SWD_OFF_CAUSE, 32'hF);
    wr(`SWD_OFF_TIMEOUT, 32'h40);
    h.kick(t);
    if (t) hang;
    wr(`SWD_OFF_KICK, 32'hA5);
    trip;
    rd(`SWD_OFF_CAUSE, 32'h4);
    wr(`SWD_OFF_CAUSE, 32'hF);
    $display("test kick done");
    wr(`SWD_OFF_TIMEOUT, 32'h2);
    ticks(0, 1);
    chk(wd_reset_req, 0);
    ticks(0, 1);
    trip;
    rd(`SWD_OFF_CAUSE, 32'h2);
    wr(`SWD_OFF_CAUSE, 32'hF);
    $display("test expiry done");
    wr(`SWD_OFF_CONFIG, 32'h4);
    wr(`SWD_OFF_TIMEOUT, 32'h2);
    fast_clock_run <= 1'b0;
    ticks(1, 3);
    ticks(0, 3);
    chk(wd_reset_req, 0);
    fast_clock_run <= 1'b1;
    ticks(1, 2);
    trip;
    $display("test clock choice done");
    stop_test;
  end
endmodule
`default_nettype wire
